// [core/carr_regs.vh]
`ifndef CARR_REGS_VH
`define CARR_REGS_VH
// Register byte offsets of the result bank
`define CARR_OFS_IBAT      8'h2F
`define CARR_OFS_VBUS      8'h31
`define CARR_OFS_VPMID     8'h33
`define CARR_OFS_VBAT      8'h35
`define CARR_OFS_VSYS      8'h37
`define CARR_OFS_TS        8'h39
// Reset value of every result
`define CARR_RESULT_RST    16'h0000
// Clamp limits in codes
`define CARR_IBAT_MAX      13'h03ED
`define CARR_IBAT_MIN      13'h1830
`define CARR_BUS_MAX       13'h0FA0
`define CARR_BAT_MAX       12'hFA0
`define CARR_TS_MAX        12'h3FF
// Field positions
`define CARR_IBAT_LSB      3
`define CARR_BUS_LSB       2
`define CARR_BAT_LSB       1
// Channel-off bit positions
`define CARR_OFF_IBAT      6
`define CARR_OFF_VBUS      5
`define CARR_OFF_VBAT      4
`define CARR_OFF_VSYS      3
`define CARR_OFF_TS        2
`define CARR_OFF_VPMID     0
`endif

// [core/carr_result_bank.v]
`include "carr_regs.vh"

// Operation
// - Battery current: 13-bit signed in 15:3, 5 mA step, clamped both ends, 2:0 zero
// - Charging current reads positive, discharging current reads negative
// - Offset 0x31 input-bus voltage unsigned in 14:2, 5 mV step, clamped high
// - Offset 0x33 mid-node voltage unsigned in 14:2, 5 mV step, clamped high
// - Battery voltage unsigned in 12:1, 1.25 mV step, clamped at FA0h
// - Offset 0x37 system voltage, same layout as battery voltage, clamped high
// - Thermistor percent unsigned in 11:0, clamped at 3FFh
// - All result registers reset to 0x0000
// - Offset 0x39 thermistor bits 15:12 read zero; bank ignores host writes
// - Rate bit: zero continuous updates, one a single update per request
// - Per-channel off bits, reset zero, freeze that channel's result
module carr_result_bank (
  input  wire        clk,          // 100 MHz clock
  input  wire        rst_n,        // Async reset, active low
  input  wire        adc_rate,     // 0 continuous, 1 one shot
  input  wire        adc_start,    // One-shot request pulse
  input  wire [7:0]  channel_off,  // Per-channel disable bits
  input  wire        sample_vld,   // Converter raw samples valid
  input  wire signed [15:0] ibat_raw, // Battery current code, signed
  input  wire [15:0] vbus_raw,     // Input-bus voltage code
  input  wire [15:0] vpmid_raw,    // Mid-node voltage code
  input  wire [15:0] vbat_raw,     // Battery voltage code
  input  wire [15:0] vsys_raw,     // System voltage code
  input  wire [15:0] ts_raw,       // Thermistor code
  input  wire        rd_en,        // Host read byte strobe
  input  wire        rd_first,     // First byte of a host read burst
  input  wire [7:0]  rd_addr,      // Host byte address
  input  wire        rd_busy,      // Host read burst in progress
  output reg  [7:0]  rd_data,      // Read byte, registered
  output reg         oneshot_busy  // One-shot conversion pending
);

  // Result registers, one per channel
  reg [15:0] battery_current_result_r;
  reg [15:0] input_bus_voltage_result_r;
  reg [15:0] mid_node_voltage_result_r;
  reg [15:0] battery_voltage_result_r;
  reg [15:0] system_voltage_result_r;
  reg [15:0] thermistor_result_r;
  // Word held for the high byte of a read burst
  reg [15:0] snap_r;
  // One-shot request state
  reg        pend_r;
  reg        pend_nxt;
  reg        take;
  // Read select path
  reg [15:0] sel;
  reg [7:0]  base;
  reg [5:0]  hit;
  reg        rd_low;
  reg        rd_snap;
  // Channel load strobes and next results
  reg [5:0]  upd;
  reg [15:0] cur_nxt;
  reg [15:0] bus_nxt;
  reg [15:0] mid_nxt;
  reg [15:0] bat_nxt;
  reg [15:0] sys_nxt;
  reg [15:0] ts_nxt;

  // Channel slots in the load strobe and address hit vectors
  localparam CH_CUR = 0;
  localparam CH_BUS = 1;
  localparam CH_MID = 2;
  localparam CH_BAT = 3;
  localparam CH_SYS = 4;
  localparam CH_TS  = 5;

  // Odd offsets hold the low byte; an even offset belongs to the word below
  function [7:0] word_base;
    input [7:0] a;
    begin
      word_base = a[0] ? a : a - 8'h01;
    end
  endfunction

  // One-hot register hit for a word base; all zero when unmapped
  function [5:0] word_hit;
    input [7:0] b;
    begin
      case (b)
        `CARR_OFS_IBAT:  word_hit = 6'h01;
        `CARR_OFS_VBUS:  word_hit = 6'h02;
        `CARR_OFS_VPMID: word_hit = 6'h04;
        `CARR_OFS_VBAT:  word_hit = 6'h08;
        `CARR_OFS_VSYS:  word_hit = 6'h10;
        `CARR_OFS_TS:    word_hit = 6'h20;
        default:         word_hit = 6'h00;
      endcase
    end
  endfunction

  // 13-bit bus voltage code placed in 14:2, other bits zero
  function [15:0] pad_bus;
    input [12:0] c;
    begin
      pad_bus = {1'b0, c, 2'h0};
    end
  endfunction

  // 12-bit cell voltage code placed in 12:1, other bits zero
  function [15:0] pad_cell;
    input [11:0] c;
    begin
      pad_cell = {3'h0, c, 1'b0};
    end
  endfunction

  // One byte of a result word; odd offsets carry bits 7:0
  function [7:0] pick_byte;
    input [15:0] w;
    input        low;
    begin
      pick_byte = low ? w[7:0] : w[15:8];
    end
  endfunction

  function [12:0] clamp_u13;
    input [15:0] v;
    input [12:0] lim;
    begin
      clamp_u13 = (v > {3'h0, lim}) ? lim : v[12:0];
    end
  endfunction

  function [11:0] clamp_u12;
    input [15:0] v;
    input [11:0] lim;
    begin
      clamp_u12 = (v > {4'h0, lim}) ? lim : v[11:0];
    end
  endfunction

  function [12:0] clamp_s13;
    input signed [15:0] v;
    begin
      if (v > $signed({3'h0, `CARR_IBAT_MAX}))
        clamp_s13 = `CARR_IBAT_MAX;
      else if (v < $signed({3'h7, `CARR_IBAT_MIN}))
        clamp_s13 = `CARR_IBAT_MIN;
      else
        clamp_s13 = v[12:0];
    end
  endfunction

  // Update gating; results never move during a host read burst
  always @* begin
    pend_nxt = pend_r;
    take     = 1'b0;
    if (sample_vld && !rd_busy) begin
      if (!adc_rate) take = 1'b1;
      else if (pend_r) begin
        take     = 1'b1;
        pend_nxt = 1'b0;
      end
    end
    if (adc_rate && adc_start) pend_nxt = 1'b1;
  end

  // Clamped and placed result of each channel from the current raw codes
  // Raw codes arrive already in result units
  always @* begin
    cur_nxt = {clamp_s13(ibat_raw), 3'h0};
    bus_nxt = pad_bus(clamp_u13(vbus_raw, `CARR_BUS_MAX));
    mid_nxt = pad_bus(clamp_u13(vpmid_raw, `CARR_BUS_MAX));
    bat_nxt = pad_cell(clamp_u12(vbat_raw, `CARR_BAT_MAX));
    sys_nxt = pad_cell(clamp_u12(vsys_raw, `CARR_BAT_MAX));
    ts_nxt  = {4'h0, clamp_u12(ts_raw, `CARR_TS_MAX)};
  end

  // A disabled channel is not loaded and keeps its last result
  always @* begin
    upd = 6'h00;
    // Only a taken sample loads anything
    if (take) begin
      upd[CH_CUR] = !channel_off[`CARR_OFF_IBAT];
      upd[CH_BUS] = !channel_off[`CARR_OFF_VBUS];
      upd[CH_MID] = !channel_off[`CARR_OFF_VPMID];
      upd[CH_BAT] = !channel_off[`CARR_OFF_VBAT];
      upd[CH_SYS] = !channel_off[`CARR_OFF_VSYS];
      upd[CH_TS]  = !channel_off[`CARR_OFF_TS];
    end
  end

  // One-shot request pending until a sample is taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r       <= 1'b0;
      oneshot_busy <= 1'b0;
    end else begin
      // A new request in the take cycle keeps the flag set
      pend_r       <= pend_nxt;
      oneshot_busy <= pend_nxt;
    end
  end

  // Battery current, signed code in 15:3
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_current_result_r <= `CARR_RESULT_RST;
    end else if (upd[CH_CUR]) begin
      battery_current_result_r <= cur_nxt;
    end
  end

  // Input-bus voltage in 14:2
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_bus_voltage_result_r <= `CARR_RESULT_RST;
    end else if (upd[CH_BUS]) begin
      input_bus_voltage_result_r <= bus_nxt;
    end
  end

  // Mid-node voltage in 14:2
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mid_node_voltage_result_r <= `CARR_RESULT_RST;
    end else if (upd[CH_MID]) begin
      mid_node_voltage_result_r <= mid_nxt;
    end
  end

  // Battery voltage in 12:1
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_voltage_result_r <= `CARR_RESULT_RST;
    end else if (upd[CH_BAT]) begin
      battery_voltage_result_r <= bat_nxt;
    end
  end

  // System voltage in 12:1
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_voltage_result_r <= `CARR_RESULT_RST;
    end else if (upd[CH_SYS]) begin
      system_voltage_result_r <= sys_nxt;
    end
  end

  // Thermistor percent in 11:0, top nibble reserved
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermistor_result_r <= `CARR_RESULT_RST;
    end else if (upd[CH_TS]) begin
      thermistor_result_r <= ts_nxt;
    end
  end

  // Register select by word base address; no write path exists
  // Unmapped addresses hit nothing and read zero
  always @* begin
    base = word_base(rd_addr);
    hit  = word_hit(base);
    sel  = ({16{hit[CH_CUR]}} & battery_current_result_r)
         | ({16{hit[CH_BUS]}} & input_bus_voltage_result_r)
         | ({16{hit[CH_MID]}} & mid_node_voltage_result_r)
         | ({16{hit[CH_BAT]}} & battery_voltage_result_r)
         | ({16{hit[CH_SYS]}} & system_voltage_result_r)
         | ({16{hit[CH_TS]}}  & thermistor_result_r);
  end

  // Byte lane and snapshot decision of the current read strobe
  always @* begin
    rd_low  = rd_addr[0];
    rd_snap = rd_en && (rd_first || rd_addr[0]);
  end

  // Word snapshot taken with the low byte, or with a first byte at an even offset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_r <= 16'h0000;
    end else if (rd_snap) begin
      snap_r <= sel;
    end
  end

  // High byte of a burst comes from the snapshot, so it pairs with its low byte
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      if (rd_first || rd_low) begin
        rd_data <= pick_byte(sel, rd_low);
      end else begin
        rd_data <= snap_r[15:8];
      end
    end
  end

endmodule // carr_result_bank

// [verif/carr_result_bank_props.sv]
module carr_result_bank_props (
  input wire logic       clk, rst_n, adc_rate, adc_start, sample_vld, // Control
  input wire logic       rd_en, rd_busy, oneshot_busy,                // Host strobes and one-shot busy flag
  input wire logic [7:0] rd_addr, rd_data                             // Byte bus
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_shot;
    adc_rate && adc_start;
  endsequence
  sequence s_take;
    adc_rate && oneshot_busy && sample_vld && !rd_busy && !adc_start;
  endsequence
  a_busy_sets: assert property (s_shot |=> oneshot_busy)
    else $error("one-shot request not pending");
  a_busy_clears: assert property (s_take |=> !oneshot_busy)
    else $error("one-shot still pending after sample");
  a_read_holds: assert property (!rd_en |=> $stable(rd_data))
    else $error("read byte changed without a read");
  a_unmapped_zero: assert property (rd_en && !(rd_addr inside {[8'h2F:8'h3A]}) |=> rd_data == 8'h00)
    else $error("unmapped byte not zero");
  a_ibat_pad: assert property (rd_en && rd_addr == 8'h2F |=> rd_data[2:0] == 3'h0)
    else $error("current low bits not zero");
  a_bus_top: assert property (rd_en && rd_addr inside {8'h32, 8'h34} |=> !rd_data[7])
    else $error("bus voltage top bit set");
  a_bat_top: assert property (rd_en && rd_addr inside {8'h36, 8'h38} |=> rd_data[7:5] == 3'h0)
    else $error("cell voltage top bits set");
  a_ts_top: assert property (rd_en && rd_addr == 8'h3A |=> rd_data[7:4] == 4'h0)
    else $error("thermistor top bits set");
endmodule // carr_result_bank_props
bind carr_result_bank carr_result_bank_props u_props (.clk, .rst_n, .adc_rate, .adc_start,
  .sample_vld, .rd_en, .rd_busy, .oneshot_busy, .rd_addr, .rd_data);

// [verif/carr_host_model.sv]
module carr_host_model (
  input  wire logic       clk,                  // Clock
  input  wire logic [7:0] rd_data,              // Read byte
  output logic            rd_en, rd_first, rd_busy, // Read strobes
  output logic      [7:0] rd_addr               // Byte address
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rd_en, rd_first, rd_busy, rd_addr} = 11'h000;
  // Low byte first so the word is snapshot before its high byte
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    {rd_en, rd_first, rd_busy, rd_addr} <= {3'h7, a};
    @(posedge clk);
    {rd_first, rd_addr} <= {1'b0, a + 8'h01};
    #1 v[7:0] = rd_data;
    @(posedge clk);
    {rd_en, rd_busy, rd_addr} <= {2'h0, ~a};
    #1 v[15:8] = rd_data;
  endtask
endmodule // carr_host_model

// [verif/carr_result_bank_tb_top.sv]
module carr_result_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, adc_rate = 0, adc_start = 0, sample_vld = 0;
  logic rd_en, rd_first, rd_busy, oneshot_busy;
  logic [7:0] channel_off = 8'h00, rd_addr, rd_data;
  logic [15:0] raw [6] = '{default: 16'h0000}, exp_r [6] = '{default: 16'h0000}, v;
  logic [31:0] seed = 32'h0000C906;
  int miscompares = 0, n_tests = 0, cyc = 0, pos [6] = '{6, 5, 0, 4, 3, 2};
  carr_result_bank dut (.clk, .rst_n, .adc_rate, .adc_start, .channel_off, .sample_vld,
    .ibat_raw(raw[0]), .vbus_raw(raw[1]), .vpmid_raw(raw[2]), .vbat_raw(raw[3]),
    .vsys_raw(raw[4]), .ts_raw(raw[5]), .rd_en, .rd_first, .rd_addr, .rd_busy, .rd_data,
    .oneshot_busy);
  carr_host_model host (.clk, .rd_data, .rd_en, .rd_first, .rd_busy, .rd_addr);
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cyc > 5000) begin
    miscompares++;
    print_verdict();
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] ex(int i, logic [15:0] r);
    int s = $signed(r);
    case (i)
      0: return 16'((s < -2000 ? -2000 : s > 1005 ? 1005 : s) * 8);
      5: return r > 16'h03FF ? 16'h03FF : r;
      default: return (r > 16'h0FA0 ? 16'h0FA0 : r) << (i < 3 ? 2 : 1);
    endcase
  endfunction
  task chk(string n, logic [15:0] s, logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check_all(string n);
    for (int i = 0; i < 6; i++) begin
      host.rd16(8'h2F + 8'(2 * i), v);
      chk(n, v, exp_r[i]);
    end
    $display("test %s done", n);
  endtask
  task automatic sample(input logic [7:0] off, input logic take);
    logic [15:0] r;
    @(posedge clk);
    sample_vld <= 1;
    channel_off <= off;
    for (int i = 0; i < 6; i++) begin
      r = 16'(xs());
      r = r[15] ? r : {4'h0, r[11:0]};
      raw[i] <= r;
      if (take && !off[pos[i]]) exp_r[i] = ex(i, r);
    end
    @(posedge clk);
    sample_vld <= 0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    check_all("reset");
    repeat (20) begin
      sample(8'h00, 1);
      check_all("random");
    end
    sample(8'h7D, 1);
    check_all("channel_off");
    @(posedge clk) adc_rate <= 1;
    sample(8'h00, 0);
    check_all("shot_idle");
    @(posedge clk) adc_start <= 1;
    @(posedge clk) adc_start <= 0;
    #1 chk("busy", {15'h0000, oneshot_busy}, 16'h0001);
    sample(8'h00, 1);
    check_all("shot_taken");
    host.rd16(8'h3C, v);
    chk("unmapped", v, 16'h0000);
    print_verdict();
  end
endmodule // carr_result_bank_tb_top
